// File: common/sfc_pkg.sv
// constants and types for the shift, flag and condition unit
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package sfc_pkg;

   //----------------------------------------------------------------
   // widths and figures
   //----------------------------------------------------------------
   localparam int          WORD_W       = 32;
   localparam int          SHAMT_W      = 8;
   localparam int          SIGN_BIT     = 31;
   localparam logic [7:0]  ROT_SPAN     = 8'h20;
   localparam logic [7:0]  CARRY_KILL   = 8'h21;
   localparam logic [31:0] PC_AHEAD     = 32'h0000_0004;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   localparam logic [3:0]  FLAGS_RESET  = 4'h0;
   localparam int          FLAG_N       = 3;
   localparam int          FLAG_Z       = 2;
   localparam int          FLAG_C       = 1;
   localparam int          FLAG_V       = 0;

   //----------------------------------------------------------------
   // operations, conditions, access sizes
   //----------------------------------------------------------------
   typedef enum logic [3:0] {
      arith_shift_right,
      logic_shift_right,
      logic_shift_left,
      rotate_right_op,
      alu_add,
      alu_sub,
      compare_subtract,
      compare_add,
      alu_move
   } sfc_op_t;

   typedef enum logic [3:0] {
      cond_equal,
      cond_not_equal,
      cond_carry_set,
      cond_carry_clear,
      cond_minus,
      cond_plus,
      cond_overflow,
      cond_no_overflow,
      cond_unsigned_higher,
      cond_unsigned_lower_same,
      cond_signed_ge,
      cond_signed_less,
      cond_signed_greater,
      cond_signed_le,
      cond_always,
      cond_reserved
   } sfc_cond_t;

   typedef enum logic [1:0] {
      size_byte,
      size_half,
      size_word,
      size_multi
   } sfc_size_t;

endpackage

// File: rtl/sfc_shifter.sv
// barrel shifter with carry-out for the four shift kinds
`timescale 1ns/10ps
module sfc_shifter (
   // request
   input  sfc_pkg::sfc_op_t  op_code,
   input  logic [31:0]       shift_source_reg,
   input  logic [7:0]        shift_len,
   // answer
   output logic [31:0]       shift_result,
   output logic              carry_out,
   output logic              carry_update
);
   import sfc_pkg::*;

   logic [4:0] low_len;
   logic       long_len;
   logic [4:0] bit_below;
   logic [4:0] bit_left;

   assign low_len   = shift_len[4:0];
   assign long_len  = (shift_len >= ROT_SPAN);
   assign bit_below = low_len - 5'h01;
   assign bit_left  = 5'h00 - low_len;

   // carry is only written for a nonzero length
   assign carry_update = (shift_len != 8'h00);

   always_comb begin
      shift_result = shift_source_reg;
      carry_out    = 1'b0;
      unique case (op_code)
         arith_shift_right,
         logic_shift_right: begin
            if (long_len) begin
               shift_result = WORD_ZERO;
               carry_out    = (shift_len == ROT_SPAN) ?
                              shift_source_reg[SIGN_BIT] : 1'b0;
            end else if (op_code == arith_shift_right) begin
               shift_result = 32'($signed(shift_source_reg) >>> low_len);
               carry_out    = shift_source_reg[bit_below];
            end else begin
               shift_result = shift_source_reg >> low_len;
               carry_out    = shift_source_reg[bit_below];
            end
         end
         logic_shift_left: begin
            if (long_len) begin
               shift_result = WORD_ZERO;
               carry_out    = (shift_len == ROT_SPAN) ?
                              shift_source_reg[0] : 1'b0;
            end else begin
               shift_result = shift_source_reg << low_len;
               carry_out    = shift_source_reg[bit_left];
            end
         end
         rotate_right_op: begin
            // only the low five bits matter: each extra 32 folds away
            if (low_len == 5'h00) begin
               shift_result = shift_source_reg;
               carry_out    = shift_source_reg[SIGN_BIT];
            end else begin
               shift_result = (shift_source_reg >> low_len) |
                              (shift_source_reg << bit_left);
               carry_out    = shift_source_reg[bit_below];
            end
         end
         default: begin
            shift_result = shift_source_reg;
            carry_out    = 1'b0;
         end
      endcase
   end

endmodule // sfc_shifter

// File: rtl/sfc_unit.sv
// shift, flag, branch condition, alignment and pc operand datapath
`timescale 1ns/10ps
module sfc_unit (
   // clock and reset
   input  logic                 clk,
   input  logic                 rst,
   // operation request
   input  logic                 op_valid,
   input  sfc_pkg::sfc_op_t     op_code,
   input  logic                 flag_update,
   input  logic [31:0]          operand_a,
   input  logic [31:0]          shift_source_reg,
   input  logic [7:0]           shift_len,
   // operation answer
   output logic [31:0]          result,
   output logic                 result_write,
   output logic [3:0]           program_status_flags,
   // conditional branch
   input  logic                 branch_valid,
   input  sfc_pkg::sfc_cond_t   branch_cond,
   output logic                 branch_taken,
   output logic                 branch_skipped,
   // memory access check
   input  logic                 access_valid,
   input  sfc_pkg::sfc_size_t   access_size,
   input  logic [31:0]          access_addr,
   output logic                 severe_fault_exception,
   // program counter operand
   input  logic [31:0]          instr_addr,
   output logic [31:0]          pc_operand
);
   import sfc_pkg::*;

   //----------------------------------------------------------------
   // shifter
   //----------------------------------------------------------------
   logic [31:0] sh_result;
   logic        sh_carry;
   logic        sh_carry_upd;

   sfc_shifter u_shifter (
      .op_code          (op_code),
      .shift_source_reg (shift_source_reg),
      .shift_len        (shift_len),
      .shift_result     (sh_result),
      .carry_out        (sh_carry),
      .carry_update     (sh_carry_upd)
   );

   //----------------------------------------------------------------
   // adder
   //----------------------------------------------------------------
   logic        is_sub;
   logic [31:0] add_b;
   logic [32:0] add_sum;
   logic [31:0] add_res;
   logic        add_ovf;

   assign is_sub  = (op_code == alu_sub) || (op_code == compare_subtract);
   assign add_b   = is_sub ? ~shift_source_reg : shift_source_reg;
   assign add_sum = {1'b0, operand_a} + {1'b0, add_b} + {32'h0000_0000, is_sub};
   assign add_res = add_sum[31:0];
   // same-sign inputs giving the other sign cannot be represented
   assign add_ovf = (operand_a[SIGN_BIT] == add_b[SIGN_BIT]) &&
                    (add_res[SIGN_BIT] != operand_a[SIGN_BIT]);

   //----------------------------------------------------------------
   // result and flags
   //----------------------------------------------------------------
   logic [31:0] next_result;
   logic        next_result_write;
   logic [3:0]  next_flags;
   logic [3:0]  flags;
   logic [31:0] op_value;
   logic        op_known;

   assign op_known = (op_code <= alu_move);

   always_comb begin
      op_value          = shift_source_reg;
      next_result       = result;
      next_result_write = 1'b0;
      next_flags        = flags;
      if (op_valid) begin
         unique case (op_code)
            arith_shift_right, logic_shift_right,
            logic_shift_left, rotate_right_op: begin
               op_value          = sh_result;
               next_result_write = 1'b1;
               if (flag_update && sh_carry_upd) begin
                  next_flags[FLAG_C] = sh_carry;
               end
            end
            alu_add, alu_sub: begin
               op_value          = add_res;
               next_result_write = 1'b1;
            end
            compare_subtract, compare_add: begin
               op_value          = add_res;
               next_result_write = 1'b0;
            end
            alu_move: begin
               op_value          = shift_source_reg;
               next_result_write = 1'b1;
            end
            default: begin
               op_value          = shift_source_reg;
               next_result_write = 1'b0;
            end
         endcase
         if (next_result_write) begin
            next_result = op_value;
         end
         // compares always set flags, the rest only when asked;
         // a spare code is a no-op and must not disturb the flags
         if (op_known && (flag_update || op_code == compare_subtract ||
             op_code == compare_add)) begin
            next_flags[FLAG_N] = op_value[SIGN_BIT];
            next_flags[FLAG_Z] = (op_value == WORD_ZERO);
            if (op_code inside {alu_add, alu_sub,
                                compare_subtract, compare_add}) begin
               next_flags[FLAG_C] = add_sum[32];
               next_flags[FLAG_V] = add_ovf;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         result       <= WORD_ZERO;
         result_write <= 1'b0;
         flags        <= FLAGS_RESET;
      end else begin
         result       <= next_result;
         result_write <= next_result_write;
         flags        <= next_flags;
      end
   end

   assign program_status_flags = flags;

   //----------------------------------------------------------------
   // branch condition
   //----------------------------------------------------------------
   logic fn;
   logic fz;
   logic fc;
   logic fv;
   logic cond_met;
   logic next_branch_taken;
   logic next_branch_skipped;

   assign fn = flags[FLAG_N];
   assign fz = flags[FLAG_Z];
   assign fc = flags[FLAG_C];
   assign fv = flags[FLAG_V];

   // evaluated on the stored flags, so any gap since they were set is fine
   always_comb begin
      cond_met = 1'b0;
      unique case (branch_cond)
         cond_equal:               cond_met = fz;
         cond_not_equal:           cond_met = !fz;
         cond_carry_set:           cond_met = fc;
         cond_carry_clear:         cond_met = !fc;
         cond_minus:               cond_met = fn;
         cond_plus:                cond_met = !fn;
         cond_overflow:            cond_met = fv;
         cond_no_overflow:         cond_met = !fv;
         cond_unsigned_higher:     cond_met = fc && !fz;
         cond_unsigned_lower_same: cond_met = !fc || fz;
         cond_signed_ge:           cond_met = (fn == fv);
         cond_signed_less:         cond_met = (fn != fv);
         cond_signed_greater:      cond_met = !fz && (fn == fv);
         cond_signed_le:           cond_met = fz || (fn != fv);
         cond_always:              cond_met = 1'b1;
         // spare code is treated as never, so it cannot redirect flow
         cond_reserved:            cond_met = 1'b0;
      endcase
   end

   always_comb begin
      next_branch_taken   = branch_valid && cond_met;
      next_branch_skipped = branch_valid && !cond_met;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         branch_taken   <= 1'b0;
         branch_skipped <= 1'b0;
      end else begin
         branch_taken   <= next_branch_taken;
         branch_skipped <= next_branch_skipped;
      end
   end

   //----------------------------------------------------------------
   // alignment check and pc operand
   //----------------------------------------------------------------
   logic        misaligned;
   logic        next_fault;
   logic [31:0] next_pc_operand;

   always_comb begin
      misaligned = 1'b0;
      unique case (access_size)
         size_byte:  misaligned = 1'b0;
         size_half:  misaligned = access_addr[0];
         size_word,
         size_multi: misaligned = (access_addr[1:0] != 2'h0);
      endcase
      next_fault      = access_valid && misaligned;
      next_pc_operand = instr_addr + PC_AHEAD;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         severe_fault_exception <= 1'b0;
         pc_operand             <= WORD_ZERO;
      end else begin
         severe_fault_exception <= next_fault;
         pc_operand             <= next_pc_operand;
      end
   end

   //----------------------------------------------------------------
   // checks
   //----------------------------------------------------------------
   logic is_shift;
   assign is_shift = op_valid && (op_code inside {arith_shift_right,
                     logic_shift_right, logic_shift_left, rotate_right_op});

   a_zero_len_hold:
   assert property (@(posedge clk) disable iff (rst)
      is_shift && shift_len == 8'h00
      |=> result == $past(shift_source_reg) &&
          flags[FLAG_C] == $past(flags[FLAG_C]))
      else $error("zero length shift changed operand or carry");

   a_asr_sign_fill:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && op_code == arith_shift_right && shift_len == 8'h01
      |=> result == {$past(shift_source_reg[31]),
                     $past(shift_source_reg[31:1])})
      else $error("arithmetic shift by one wrong");

   a_lsr_carry_bit:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && flag_update && op_code == logic_shift_right &&
      shift_len == 8'h04
      |=> flags[FLAG_C] == $past(shift_source_reg[3]) &&
          result[31:28] == 4'h0)
      else $error("logical right shift by four carry or fill wrong");

   a_lsl_carry_bit:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && flag_update && op_code == logic_shift_left &&
      shift_len == 8'h04
      |=> flags[FLAG_C] == $past(shift_source_reg[28]) &&
          result[3:0] == 4'h0)
      else $error("logical left shift by four carry or fill wrong");

   a_long_shift_zero:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && op_code != rotate_right_op && is_shift &&
      shift_len >= ROT_SPAN
      |=> result == WORD_ZERO && flags[FLAG_Z] == ($past(flag_update) |
          $past(flags[FLAG_Z])))
      else $error("long shift result not zero");

   a_carry_kill:
   assert property (@(posedge clk) disable iff (rst)
      is_shift && flag_update && op_code != rotate_right_op &&
      shift_len >= CARRY_KILL
      |=> !flags[FLAG_C])
      else $error("shift of 33 or more left carry set");

   a_rotate_span:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && flag_update && op_code == rotate_right_op &&
      shift_len == ROT_SPAN
      |=> result == $past(shift_source_reg) &&
          flags[FLAG_C] == $past(shift_source_reg[31]))
      else $error("rotate by 32 wrong");

   a_compare_no_write:
   assert property (@(posedge clk) disable iff (rst)
      op_valid && op_code == compare_subtract
      |=> !result_write && result == $past(result) &&
          flags[FLAG_Z] == ($past(operand_a) == $past(shift_source_reg)))
      else $error("compare wrote a result or zero flag wrong");

   a_flags_keep:
   assert property (@(posedge clk) disable iff (rst)
      !op_valid ##1 !op_valid |-> $stable(flags))
      else $error("flags moved without an operation");

   a_branch_higher:
   assert property (@(posedge clk) disable iff (rst)
      branch_valid && branch_cond == cond_unsigned_higher
      |=> branch_taken == ($past(fc) && !$past(fz)) &&
          branch_skipped != branch_taken)
      else $error("unsigned higher branch decision wrong");

   a_fault_halfword:
   assert property (@(posedge clk) disable iff (rst)
      access_valid && access_size == size_half
      |=> severe_fault_exception == $past(access_addr[0]))
      else $error("halfword alignment fault wrong");

   a_pc_ahead:
   assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> pc_operand == $past(instr_addr) + PC_AHEAD)
      else $error("pc operand not address plus four");

endmodule // sfc_unit

// File: tb/sfc_regfile_model.sv
// register file model that collects the results the unit writes back
`timescale 1ns/10ps
module sfc_regfile_model (
   // clock and reset
   input  logic        clk,
   input  logic        rst,
   // write port from the unit
   input  logic        result_write,
   input  logic [31:0] result,
   // observation
   output logic [31:0] last_written,
   output logic [15:0] write_count
);
   // counting writes lets the bench prove compares never write back
   always_ff @(posedge clk) begin
      if (rst) begin
         last_written <= 32'h0000_0000;
         write_count  <= 16'h0000;
      end else if (result_write) begin
         last_written <= result;
         write_count  <= write_count + 16'h0001;
      end
   end
endmodule // sfc_regfile_model

// File: tb/shift_flag_condition_unit_tb_top.sv
// self-checking bench for the shift, flag and condition unit
`timescale 1ns/10ps
module shift_flag_condition_unit_tb_top;
   import sfc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, flag_update = 1'b0;
   sfc_op_t     op_code = alu_move;
   logic [31:0] operand_a = 32'h0000_0000, shift_source_reg = 32'h0000_0000;
   logic [7:0]  shift_len = 8'h00;
   logic [31:0] result, pc_operand, last_written;
   logic        result_write, branch_taken, branch_skipped, fault;
   logic [3:0]  program_status_flags;
   logic        branch_valid = 1'b0, access_valid = 1'b0;
   sfc_cond_t   branch_cond = cond_always;
   sfc_size_t   access_size = size_byte;
   logic [31:0] access_addr = 32'h0000_0000, instr_addr = 32'h0000_0000;
   logic [15:0] write_count;
   int miscompares = 0, num_checks = 0, exp_writes = 0;
   logic [3:0]  ef;
   logic [31:0] er;

   always #12.5 clk = ~clk;

   sfc_unit DUT (.clk(clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .flag_update(flag_update), .operand_a(operand_a),
      .shift_source_reg(shift_source_reg), .shift_len(shift_len),
      .result(result), .result_write(result_write),
      .program_status_flags(program_status_flags),
      .branch_valid(branch_valid), .branch_cond(branch_cond),
      .branch_taken(branch_taken), .branch_skipped(branch_skipped),
      .access_valid(access_valid), .access_size(access_size),
      .access_addr(access_addr), .severe_fault_exception(fault),
      .instr_addr(instr_addr), .pc_operand(pc_operand));

   sfc_regfile_model rf (.clk(clk), .rst(rst), .result_write(result_write),
      .result(result), .last_written(last_written),
      .write_count(write_count));

   //----------------------------------------------------------------
   // compare tasks and closing
   //----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   //----------------------------------------------------------------
   // access tasks: drive after the edge, answer one edge later
   //----------------------------------------------------------------
   task automatic do_op(input sfc_op_t op, input logic fu,
      input logic [31:0] a, input logic [31:0] b, input logic [7:0] n);
      @(posedge clk);
      #1 op_valid = 1'b1;
      op_code = op;
      flag_update = fu;
      operand_a = a;
      shift_source_reg = b;
      shift_len = n;
      @(posedge clk);
      #1 op_valid = 1'b0;
   endtask

   task automatic do_branch(input int c);
      @(posedge clk);
      #1 branch_valid = 1'b1;
      branch_cond = sfc_cond_t'(c[3:0]);
      @(posedge clk);
      #1 branch_valid = 1'b0;
   endtask

   task automatic do_access(input int s, input logic [31:0] ad);
      @(posedge clk);
      #1 access_valid = 1'b1;
      access_size = sfc_size_t'(s[1:0]);
      access_addr = ad;
      @(posedge clk);
      #1 access_valid = 1'b0;
   endtask

   //----------------------------------------------------------------
   // expected values
   //----------------------------------------------------------------
   function automatic void exp_shift(input sfc_op_t op, input logic [31:0] s,
      input logic [7:0] n, output logic [31:0] r, output logic c);
      int m;
      m = n % 32;
      c = 1'b0;
      r = s;
      if (op == rotate_right_op && n != 8'h00) begin
         r = (m == 0) ? s : ((s >> m) | (s << (32 - m)));
         c = (m == 0) ? s[31] : s[m - 1];
      end else if (n != 8'h00) begin
         r = (op == logic_shift_left) ? (s << n) :
             (op == logic_shift_right) ? (s >> n) : 32'($signed(s) >>> n);
         if (n >= 8'h20) r = 32'h0000_0000;
         if (n <= 8'h20)
            c = (op == logic_shift_left) ? s[32 - n] : s[n - 1];
      end
   endfunction

   function automatic logic cond_ok(input int c, input logic [3:0] f);
      logic n, z, k, v;
      {n, z, k, v} = f;
      case (c)
         0: return z;
         1: return !z;
         2: return k;
         3: return !k;
         4: return n;
         5: return !n;
         6: return v;
         7: return !v;
         8: return k && !z;
         9: return !k || z;
         10: return n == v;
         11: return n != v;
         12: return !z && (n == v);
         13: return z || (n != v);
         14: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   //----------------------------------------------------------------
   // tests
   //----------------------------------------------------------------
   sfc_op_t     sh_op [4] = '{arith_shift_right, logic_shift_right,
                              logic_shift_left, rotate_right_op};
   logic [7:0]  lens [8] = '{8'h00, 8'h01, 8'h04, 8'h1F, 8'h20, 8'h21,
                             8'h40, 8'hFF};
   sfc_op_t     arith_op [8] = '{alu_add, alu_add, alu_sub, alu_sub, alu_sub,
                                 compare_subtract, compare_add, alu_move};
   logic [31:0] arith_a [8] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0000_0005,
      32'h0000_0003, 32'h8000_0000, 32'h0000_0003, 32'h7FFF_FFFF, 32'h0};
   logic [31:0] arith_b [8] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0005,
      32'h0000_0005, 32'h0000_0001, 32'h0000_0005, 32'h0000_0001,
      32'h8000_0000};

   initial begin
      logic [31:0] s, r;
      logic [32:0] w;
      logic c, fu, sub;
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      chk(result, 32'h0000_0000);
      chk({28'h0, program_status_flags}, {28'h0, FLAGS_RESET});
      ef = FLAGS_RESET;
      er = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 8; j++) begin
            s = j[0] ? 32'h8000_00F1 : 32'h7FFF_FF0E;
            fu = (j != 3);
            exp_shift(sh_op[i], s, lens[j], er, c);
            if (fu) ef = {er[31], er == 32'h0, (lens[j] != 8'h00) ? c : ef[1],
                          ef[0]};
            do_op(sh_op[i], fu, 32'h0, s, lens[j]);
            exp_writes++;
            chk({31'h0, result_write}, 32'h1);
            chk(result, er);
            chk({28'h0, program_status_flags}, {28'h0, ef});
         end
      end
      for (int i = 0; i < 8; i++) begin
         sub = (arith_op[i] == alu_sub || arith_op[i] == compare_subtract);
         w = sub ? ({1'b0, arith_a[i]} - {1'b0, arith_b[i]}) :
                   ({1'b0, arith_a[i]} + {1'b0, arith_b[i]});
         r = (arith_op[i] == alu_move) ? arith_b[i] : w[31:0];
         c = sub ? (arith_a[i] >= arith_b[i]) : w[32];
         ef = (arith_op[i] == alu_move) ? {r[31], r == 32'h0, ef[1:0]} :
              {r[31], r == 32'h0, c,
               ((arith_a[i][31] ^ arith_b[i][31]) == sub) &&
               (r[31] != arith_a[i][31])};
         if (arith_op[i] != compare_subtract &&
             arith_op[i] != compare_add) begin
            er = r;
            exp_writes++;
         end
         do_op(arith_op[i], 1'b1, arith_a[i], arith_b[i], 8'h04);
         chk(result, er);
         chk({28'h0, program_status_flags}, {28'h0, ef});
         // a non-flag op between setting and testing the flags
         do_op(rotate_right_op, 1'b0, 32'h0, 32'h0000_1234, 8'h08);
         er = 32'h3400_0012;
         exp_writes++;
         for (int k = 0; k < 16; k++) begin
            do_branch(k);
            chk({31'h0, branch_taken}, {31'h0, cond_ok(k, ef)});
            chk({31'h0, branch_skipped}, {31'h0, !cond_ok(k, ef)});
         end
      end
      // a spare operation code must leave result and flags alone
      do_op(sfc_op_t'(4'hC), 1'b1, 32'h0, 32'h0, 8'h00);
      chk(result, er);
      chk({28'h0, program_status_flags}, {28'h0, ef});
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 4; j++) begin
            do_access(i, 32'h2000_0000 | j);
            chk({31'h0, fault}, (i == 0) ? 32'h0 : (i == 1) ? j & 1 :
                                32'(j != 0));
         end
      end
      foreach (arith_a[i]) begin
         @(posedge clk);
         #1 instr_addr = arith_a[i] & 32'hFFFF_FFFE;
         @(posedge clk);
         #1 chk(pc_operand, (arith_a[i] & 32'hFFFF_FFFE) + 32'h0000_0004);
      end
      @(posedge clk);
      #1 chk({16'h0, write_count}, 32'(exp_writes));
      chk(last_written, er);
      report_and_stop();
   end

   initial begin
      #(25 * 4000);
      miscompares++;
      report_and_stop();
   end
endmodule // shift_flag_condition_unit_tb_top
